/* File: udl_pkg.sv */
// Constants for the serial port divisor and line-control block.
// Assumes a 32-bit word register port with byte offsets.
package udl_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_LP_DIV = 12'h020;
  localparam logic [11:0] OFS_IBRD = 12'h024;
  localparam logic [11:0] OFS_FBRD = 12'h028;
  localparam logic [11:0] OFS_LCTL = 12'h02c;
  localparam logic [11:0] OFS_IRCTL = 12'h030;
  localparam logic [11:0] OFS_STAT = 12'h034;

  ////////////////////////////////////////////////////////////////////
  // Field widths
  localparam int LP_DIV_W = 8;
  localparam int IBRD_W = 16;
  localparam int FBRD_W = 6;
  localparam int LCTL_W = 8;

  // Line control field positions
  localparam int LC_BRK = 0;
  localparam int LC_PEN = 1;
  localparam int LC_EPS = 2;
  localparam int LC_TWO_STOP_BIT_SETTING = 3;
  localparam int LC_FEN = 4;
  localparam int LC_WLEN_LO = 5;
  localparam int LC_SPS = 7;

  // Infrared control and status positions
  localparam int IR_LP_EN = 0;
  localparam int ST_PEND = 0;
  localparam int ST_LP_ZERO = 1;

  ////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [LP_DIV_W-1:0] LP_DIV_RST = 8'h00;
  localparam logic [IBRD_W-1:0] IBRD_RST = 16'h0000;
  localparam logic [FBRD_W-1:0] FBRD_RST = 6'h00;
  localparam logic [LCTL_W-1:0] LCTL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////
  // Infrared pulse length in ticks and minimum data bits
  localparam logic [1:0] SIR_PULSE_TICKS = 2'h3;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;

  // Infrared transmit pulse states
  typedef enum logic [1:0] {
    SIR_IDLE = 2'b01,
    SIR_PULSE = 2'b10
  } udl_sir_state_t;

endpackage : udl_pkg

/* File: udl_baud_gen.sv */
// Sixteen-times baud tick generator with fractional accumulation.
// Assumes the divisor inputs are stable except across a reload pulse.
`timescale 1ns/10ps
module udl_baud_gen #(
  parameter int IW = 16,
  parameter int FW = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Divisor
  input wire logic [IW-1:0] int_div_i,
  input wire logic [FW-1:0] frac_div_i,
  input wire logic reload_i,
  // Tick out
  output logic tick_o
);

  logic [IW-1:0] cnt_q; // Cycles left in this period
  logic [IW-1:0] cnt_d;
  logic [FW-1:0] acc_q; // Fraction accumulator
  logic [FW-1:0] acc_d;
  logic [FW:0] acc_sum; // Sum with carry
  logic int_zero; // Ratio of one requested
  logic at_end; // Period ends this cycle

  ////////////////////////////////////////////////////////////////////
  // Period arithmetic
  assign int_zero = (int_div_i == '0);
  assign acc_sum = {1'b0, acc_q} + {1'b0, frac_div_i};
  assign at_end = (cnt_q == '0);
  // Zero integer: tick each cycle, fraction ignored
  assign tick_o = at_end; // R15 R7

  // Next count: integer minus one, plus one on fraction carry
  always_comb begin
    cnt_d = cnt_q;
    acc_d = acc_q;
    if (reload_i || int_zero) begin
      cnt_d = '0; // R7
      acc_d = '0;
    end else if (at_end) begin
      acc_d = acc_sum[FW-1:0]; // R15
      cnt_d = int_div_i - IW'(1) + IW'(acc_sum[FW]);
    end else begin
      cnt_d = cnt_q - IW'(1);
    end
  end

  // Counter registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      acc_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
    end
  end

endmodule : udl_baud_gen

/* File: udl_top.sv */
// Divisor, line-control and infrared pulse timing of a serial port.
// Assumes a shift engine that reports character activity and samples
// the frame settings, and an infrared transceiver on sir_rx_i.
`timescale 1ns/10ps

// Behaviour
// R1: Eight-bit divisor makes low-power tick
// R2: Infrared pulse lasts three low-power ticks; code uses three baud ticks outside low-power mode
// R3: Zero divisor gives no low-power ticks
// R4: Reject received pulses shorter than tick; code filters only in low-power mode
// R5: Software keeps tick near 1.8432 MHz
// R6: Sixteen-bit integer divisor, reset zero
// R7: Integer zero means ratio one
// R8: New divisor waits for character end
// R9: Six-bit fractional divisor, reset zero
// R10: Divisors apply on line control write
// R11: FIFO enable, else one-byte holding
// R12: Two stop bits sent, one checked
// R13: Parity bit added and checked when enabled
// R14: Even or odd parity select
// R15: Fractional baud tick from both divisors
module udl_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Shift engine interface
  input wire logic char_busy_i,
  input wire logic [7:0] tx_data_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  output logic baud_x16_tick_o,
  output logic low_power_x16_tick_o,
  output logic tx_parity_bit_o,
  output logic rx_parity_err_o,
  output logic [3:0] tx_frame_bits_o,
  output logic [3:0] rx_frame_bits_o,
  output logic [1:0] tx_stop_bits_o,
  output logic [7:0] fifo_depth_o,
  output logic break_o,
  // Infrared pulse path
  input wire logic sir_tx_req_i,
  input wire logic sir_rx_i,
  output logic sir_tx_o,
  output logic sir_rx_pulse_o
);

  ////////////////////////////////////////////////////////////////////
  // Register decode

  logic sel_lp; // Address hits
  logic sel_ibrd;
  logic sel_fbrd;
  logic sel_lctl;
  logic sel_irctl;
  logic sel_stat;
  logic wr_lctl; // Line control write strobe

  assign sel_lp = (reg_addr_i == udl_pkg::OFS_LP_DIV);
  assign sel_ibrd = (reg_addr_i == udl_pkg::OFS_IBRD);
  assign sel_fbrd = (reg_addr_i == udl_pkg::OFS_FBRD);
  assign sel_lctl = (reg_addr_i == udl_pkg::OFS_LCTL);
  assign sel_irctl = (reg_addr_i == udl_pkg::OFS_IRCTL);
  assign sel_stat = (reg_addr_i == udl_pkg::OFS_STAT);
  assign wr_lctl = reg_wr_i && sel_lctl;

  ////////////////////////////////////////////////////////////////////
  // Software-visible registers

  logic [udl_pkg::LP_DIV_W-1:0] lp_div_q; // Low-power divide value
  logic [udl_pkg::IBRD_W-1:0] ibrd_q; // Integer divide value, staged
  logic [udl_pkg::FBRD_W-1:0] fbrd_q; // Fraction divide value, staged
  logic [udl_pkg::LCTL_W-1:0] lctl_q; // Line control
  logic lp_en_q; // Infrared low-power mode

  // Plain register writes, one word per offset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lp_div_q <= udl_pkg::LP_DIV_RST; // R1
      ibrd_q <= udl_pkg::IBRD_RST; // R6
      fbrd_q <= udl_pkg::FBRD_RST; // R9
      lctl_q <= udl_pkg::LCTL_RST;
      lp_en_q <= 1'b0;
    end else if (reg_wr_i) begin
      if (sel_lp) begin
        lp_div_q <= reg_wdata_i[udl_pkg::LP_DIV_W-1:0]; // R1
      end
      if (sel_ibrd) begin
        ibrd_q <= reg_wdata_i[udl_pkg::IBRD_W-1:0]; // R6
      end
      if (sel_fbrd) begin
        fbrd_q <= reg_wdata_i[udl_pkg::FBRD_W-1:0]; // R9
      end
      if (sel_lctl) begin
        lctl_q <= reg_wdata_i[udl_pkg::LCTL_W-1:0];
      end
      if (sel_irctl) begin
        lp_en_q <= reg_wdata_i[udl_pkg::IR_LP_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Divisor staging: the baud generator only ever sees the active copy,
  // so a half-written divisor pair never reaches the line.

  logic [udl_pkg::IBRD_W-1:0] ibrd_act_q; // Divisor in use
  logic [udl_pkg::FBRD_W-1:0] fbrd_act_q;
  logic pend_q; // Update waiting for idle
  logic pend_d;
  logic apply; // Copy staged divisor now

  // Apply only between characters
  assign apply = pend_q && !char_busy_i; // R8
  // A new line control write wins over the apply clearing the flag
  assign pend_d = wr_lctl || (pend_q && !apply); // R10

  // Pending flag and active divisor copy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      ibrd_act_q <= udl_pkg::IBRD_RST;
      fbrd_act_q <= udl_pkg::FBRD_RST;
    end else begin
      pend_q <= pend_d; // R10
      if (apply) begin
        ibrd_act_q <= ibrd_q; // R8
        fbrd_act_q <= fbrd_q; // R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sixteen-times baud tick

  udl_baud_gen #(
    .IW(udl_pkg::IBRD_W),
    .FW(udl_pkg::FBRD_W)
  ) u_baud (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .int_div_i(ibrd_act_q),
    .frac_div_i(fbrd_act_q),
    .reload_i(apply),
    .tick_o(baud_x16_tick_o) // R15
  );

  ////////////////////////////////////////////////////////////////////
  // Low-power tick divider

  logic [udl_pkg::LP_DIV_W-1:0] lp_cnt_q; // Cycles into period
  logic lp_zero; // Illegal divide value
  logic lp_tick; // One-cycle tick

  assign lp_zero = (lp_div_q == '0);
  // Zero divisor never produces a tick
  assign lp_tick = !lp_zero && (lp_cnt_q == lp_div_q - 8'h01); // R3 R1
  assign low_power_x16_tick_o = lp_tick;

  // Count system clocks up to the divide value
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lp_cnt_q <= '0;
    end else if (lp_zero || lp_tick) begin
      lp_cnt_q <= '0; // R3
    end else begin
      lp_cnt_q <= lp_cnt_q + 8'h01; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Infrared transmit pulse: three ticks of the chosen clock.
  // Normal mode uses the baud tick; as the request is not tick-aligned, the pulse lasts just over 2/16 to 3/16 bit.

  udl_pkg::udl_sir_state_t sir_q;
  udl_pkg::udl_sir_state_t sir_d;
  logic [1:0] sir_cnt_q; // Ticks in current pulse
  logic [1:0] sir_cnt_d;
  logic sir_tick; // Selected pulse clock

  assign sir_tick = lp_en_q ? lp_tick : baud_x16_tick_o; // R2

  // Pulse sequencer
  always_comb begin
    sir_d = sir_q;
    sir_cnt_d = sir_cnt_q;
    unique case (sir_q)
      udl_pkg::SIR_IDLE: begin
        // Start a pulse on request
        if (sir_tx_req_i) begin
          sir_d = udl_pkg::SIR_PULSE;
          sir_cnt_d = '0;
        end
      end
      udl_pkg::SIR_PULSE: begin
        // End after exactly three ticks
        if (sir_tick) begin
          sir_cnt_d = sir_cnt_q + 2'h1;
          if (sir_cnt_q == udl_pkg::SIR_PULSE_TICKS - 2'h1) begin
            sir_d = udl_pkg::SIR_IDLE; // R2
          end
        end
      end
      default: begin
        sir_d = udl_pkg::SIR_IDLE;
      end
    endcase
  end

  // Sequencer state; output straight from the state flop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sir_q <= udl_pkg::SIR_IDLE;
      sir_cnt_q <= '0;
    end else begin
      sir_q <= sir_d;
      sir_cnt_q <= sir_cnt_d;
    end
  end

  assign sir_tx_o = (sir_q == udl_pkg::SIR_PULSE); // R2

  ////////////////////////////////////////////////////////////////////
  // Infrared receive filter. The pin is synchronised first; width is
  // measured in system clocks against the low-power divide value, which
  // is exactly one tick period without waiting for tick alignment.

  logic rx_meta_q; // First synchroniser stage
  logic rx_sync_q; // Second synchroniser stage
  logic rx_prev_q; // For edge detection
  logic [udl_pkg::LP_DIV_W-1:0] rx_wid_q; // Saturating width count
  logic rx_long; // Pulse reached one period
  logic rx_fall; // Pulse just ended
  logic rx_pulse_q; // Accepted pulse marker

  assign rx_long = (rx_wid_q >= lp_div_q);
  assign rx_fall = rx_prev_q && !rx_sync_q;

  // Synchroniser and width counter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
      rx_prev_q <= 1'b0;
      rx_wid_q <= '0;
      rx_pulse_q <= 1'b0;
    end else begin
      rx_meta_q <= sir_rx_i;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
      if (!rx_sync_q) begin
        rx_wid_q <= '0;
      end else if (rx_wid_q != 8'hff) begin
        rx_wid_q <= rx_wid_q + 8'h01;
      end
      // Normal mode passes every pulse; low-power mode filters short ones
      rx_pulse_q <= rx_fall && (!lp_en_q || (!lp_zero && rx_long)); // R4
    end
  end

  assign sir_rx_pulse_o = rx_pulse_q;

  ////////////////////////////////////////////////////////////////////
  // Frame format decode

  logic parity_enable_setting; // Parity enable
  logic even_parity_setting; // Even parity
  logic sps; // Stick parity
  logic two_stop_bit_setting; // Two stop bits
  logic [1:0] wlen; // Word length code
  logic [3:0] data_bits; // Five to eight
  logic [7:0] len_mask; // Valid data bits
  logic tx_par; // Computed parity bit
  logic rx_par_exp; // Expected parity bit

  assign parity_enable_setting = lctl_q[udl_pkg::LC_PEN];
  assign even_parity_setting = lctl_q[udl_pkg::LC_EPS];
  assign sps = lctl_q[udl_pkg::LC_SPS];
  assign two_stop_bit_setting = lctl_q[udl_pkg::LC_TWO_STOP_BIT_SETTING];
  assign wlen = lctl_q[udl_pkg::LC_WLEN_LO +: 2];
  assign data_bits = udl_pkg::MIN_DATA_BITS + {2'b00, wlen};
  assign len_mask = 8'hff >> (3'h3 - {1'b0, wlen});
  // Even total count with even select, odd otherwise; stick forces level
  assign tx_par = sps ? !even_parity_setting : (even_parity_setting ? ^(tx_data_i & len_mask)
                                     : ~^(tx_data_i & len_mask)); // R14
  assign rx_par_exp = sps ? !even_parity_setting : (even_parity_setting ? ^(rx_data_i & len_mask)
                                         : ~^(rx_data_i & len_mask)); // R14

  // Registered frame settings for the shift engine
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_parity_bit_o <= 1'b0;
      rx_parity_err_o <= 1'b0;
      tx_frame_bits_o <= 4'h0;
      rx_frame_bits_o <= 4'h0;
      tx_stop_bits_o <= 2'h0;
      fifo_depth_o <= 8'h00;
      break_o <= 1'b0;
    end else begin
      tx_parity_bit_o <= parity_enable_setting && tx_par; // R13
      rx_parity_err_o <= parity_enable_setting && (rx_parity_i != rx_par_exp); // R13
      // Start, data, optional parity and stops
      tx_frame_bits_o <= 4'h1 + data_bits + {3'h0, parity_enable_setting} + (two_stop_bit_setting ? 4'h2 : 4'h1); // R12
      // Receiver only ever checks one stop bit
      rx_frame_bits_o <= 4'h2 + data_bits + {3'h0, parity_enable_setting}; // R12
      tx_stop_bits_o <= two_stop_bit_setting ? 2'h2 : 2'h1; // R12
      fifo_depth_o <= lctl_q[udl_pkg::LC_FEN] ? 8'(FIFO_DEPTH) : 8'h01; // R11
      break_o <= lctl_q[udl_pkg::LC_BRK];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data: valid only in the cycle after the read strobe

  logic [31:0] rd_mux; // Selected word

  assign rd_mux = sel_lp ? {24'h0, lp_div_q} :
                  sel_ibrd ? {16'h0, ibrd_q} :
                  sel_fbrd ? {26'h0, fbrd_q} :
                  sel_lctl ? {24'h0, lctl_q} :
                  sel_irctl ? {31'h0, lp_en_q} :
                  sel_stat ? {30'h0, lp_zero, pend_q} :
                  32'h0;

  // Unmapped addresses read as zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

endmodule : udl_top

/* File: udl_checker.sv */
// Checker: port-level assertions for the divisor and line-control block.
// Assumes one clock domain and a bind onto udl_top from the bench.
`timescale 1ns/10ps
module udl_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Engine side
  input wire logic [7:0] tx_data_i,
  input wire logic baud_x16_tick_o,
  input wire logic low_power_x16_tick_o,
  input wire logic tx_parity_bit_o,
  input wire logic [3:0] tx_frame_bits_o,
  input wire logic [3:0] rx_frame_bits_o,
  input wire logic [1:0] tx_stop_bits_o,
  input wire logic [7:0] fifo_depth_o,
  // Infrared transmit
  input wire logic sir_tx_req_i,
  input wire logic sir_tx_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////
  logic [7:0] lc_q; // Line control as written
  logic [7:0] lcd_q; // Same, one cycle later, as the outputs see it
  logic [7:0] lpd_q; // Low-power divisor
  logic lpen_q; // Low-power enable
  logic up_q; // Outputs settled after reset
  logic chg_q; // Divisor touched since the last low-power tick
  logic [7:0] gap_q; // Cycles since the last low-power tick
  logic [2:0] tk_q; // Ticks seen during an infrared pulse
  wire wr_lc = reg_wr_i && reg_addr_i == udl_pkg::OFS_LCTL;
  wire wr_lp = reg_wr_i && reg_addr_i == udl_pkg::OFS_LP_DIV;
  wire wr_ir = reg_wr_i && reg_addr_i == udl_pkg::OFS_IRCTL;
  wire rd_lp = reg_rd_i && reg_addr_i == udl_pkg::OFS_LP_DIV;
  // Pulse length runs on whichever tick the enable picks
  wire pick_tick = lpen_q ? low_power_x16_tick_o : baud_x16_tick_o;
  wire [3:0] rx_bits = 4'h7 + {2'h0, lcd_q[6:5]} + {3'h0, lcd_q[1]};

  // Shadows mirror software writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lc_q <= 8'h00;
      lcd_q <= 8'h00;
      lpd_q <= 8'h00;
      lpen_q <= 1'b0;
      up_q <= 1'b0;
    end else begin
      lc_q <= wr_lc ? reg_wdata_i[7:0] : lc_q;
      lcd_q <= lc_q;
      lpd_q <= wr_lp ? reg_wdata_i[7:0] : lpd_q;
      lpen_q <= wr_ir ? reg_wdata_i[0] : lpen_q;
      up_q <= 1'b1;
    end
  end

  // Tick spacing; first gap after a write is skipped, phase is unknown
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chg_q <= 1'b1;
      gap_q <= 8'h00;
      tk_q <= 3'h0;
    end else begin
      chg_q <= wr_lp || (chg_q && !low_power_x16_tick_o);
      gap_q <= low_power_x16_tick_o ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
      tk_q <= !sir_tx_o ? 3'h0 : tk_q + {2'h0, pick_tick};
    end
  end

  // Parity bit expected for a setting and a data byte
  function automatic logic par_f(input logic [7:0] lc, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - lc[6:5]));
    if (!lc[1]) return 1'b0;
    if (lc[7]) return !lc[2];
    return lc[2] ? ^m : ~^m;
  endfunction : par_f

  ////////////////////////////////////////////////////////////////////
  lp_read_a: assert property (
    up_q && $past(rd_lp)
    |-> reg_rdata_o == {24'h0, $past(lpd_q)}) else $error("Low-power divisor read wrong");
  lp_zero_quiet_a: assert property (
    lpd_q == 8'h00 && $past(lpd_q) == 8'h00 |-> !low_power_x16_tick_o)
    else $error("Low-power tick with zero divisor");
  lp_period_a: assert property (
    low_power_x16_tick_o && !chg_q |-> gap_q == lpd_q - 8'h01)
    else $error("Low-power tick spacing off");
  tx_start_a: assert property (
    $rose(sir_tx_o) |-> $past(sir_tx_req_i)) else $error("Infrared pulse without request");
  tx_three_a: assert property (
    up_q && $fell(sir_tx_o) |-> tk_q == 3'h3) else $error("Infrared pulse ended early");
  tx_no_more_a: assert property (
    tk_q == 3'h3 |-> !sir_tx_o) else $error("Infrared pulse outlasts three ticks");
  stop_bits_a: assert property (
    up_q |-> tx_stop_bits_o == (lcd_q[3] ? 2'h2 : 2'h1)) else $error("Stop bit count wrong");
  frame_bits_a: assert property (
    up_q |-> tx_frame_bits_o == rx_bits + {3'h0, lcd_q[3]} && rx_frame_bits_o == rx_bits)
    else $error("Frame length wrong");
  fifo_depth_a: assert property (
    up_q |-> fifo_depth_o == (lcd_q[4] ? 8'(FIFO_DEPTH) : 8'h01))
    else $error("FIFO depth wrong");
  tx_parity_a: assert property (
    up_q |-> tx_parity_bit_o == par_f(lcd_q, $past(tx_data_i)))
    else $error("Transmit parity bit wrong");
endmodule : udl_checker

/* File: udl_ir_xcvr.sv */
// Behavioural infrared transceiver on the block's pulse pins.
// Assumes the bench asks for receive pulses; shares the block clock.
`timescale 1ns/10ps
module udl_ir_xcvr (
  // Clock
  input wire logic clk_i,
  // Bench control
  input wire logic send_i,
  input wire logic [8:0] width_i,
  // Line side
  input wire logic sir_tx_i,
  output logic sir_rx_o,
  output logic [9:0] tx_width_o
);
  logic [8:0] left_q = 9'h000; // Clocks of pulse still to send
  logic [9:0] run_q = 10'h000; // Length of current transmit pulse

  ////////////////////////////////////////////////////////////////////
  // Pin idles low; a pulse is one high run of the asked width
  always_ff @(posedge clk_i) begin
    if (send_i) begin
      left_q <= width_i;
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
    end
  end
  assign sir_rx_o = left_q != 9'h000;

  // Measures each transmit pulse for the bench; unknown until the first one
  always_ff @(posedge clk_i) begin
    run_q <= sir_tx_i ? run_q + 10'h001 : 10'h000;
    if (!sir_tx_i && run_q != 10'h000) begin
      tx_width_o <= run_q;
    end
  end
endmodule : udl_ir_xcvr

/* File: tb.sv */
// Bench: register-port tests of the divisor and line-control block.
// Assumes udl_top, udl_checker and udl_ir_xcvr are compiled first.
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] LPD = 8'h88;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, char_busy_i = 1'b0, sir_tx_req_i = 1'b0;
  logic rx_parity_i = 1'b0, send = 1'b0;
  logic [7:0] tx_data_i = 8'h00, rx_data_i = 8'h00;
  logic [8:0] width = 9'h000;
  logic [31:0] reg_rdata_o;
  logic baud_x16_tick_o, low_power_x16_tick_o, tx_parity_bit_o, rx_parity_err_o;
  logic sir_tx_o, sir_rx_pulse_o, sir_rx_i, break_o;
  logic [3:0] tx_frame_bits_o, rx_frame_bits_o;
  logic [1:0] tx_stop_bits_o;
  logic [7:0] fifo_depth_o;
  logic [9:0] tx_width;
  logic [11:0] offs [5] = '{12'h020, 12'h024, 12'h028, 12'h02c, 12'h030};
  logic [31:0] masks [5] = '{32'hff, 32'hffff, 32'h3f, 32'hff, 32'h1};
  logic [7:0] lcs [5] = '{8'h60, 8'h62, 8'h66, 8'h7e, 8'h73};
  int err_count = 0, samples_checked = 0, cyc = 0, acc = 0;

  udl_top #(.FIFO_DEPTH(16)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .char_busy_i(char_busy_i),
    .tx_data_i(tx_data_i), .rx_data_i(rx_data_i), .rx_parity_i(rx_parity_i),
    .baud_x16_tick_o(baud_x16_tick_o), .low_power_x16_tick_o(low_power_x16_tick_o),
    .tx_parity_bit_o(tx_parity_bit_o), .rx_parity_err_o(rx_parity_err_o),
    .tx_frame_bits_o(tx_frame_bits_o), .rx_frame_bits_o(rx_frame_bits_o),
    .tx_stop_bits_o(tx_stop_bits_o), .fifo_depth_o(fifo_depth_o), .break_o(break_o),
    .sir_tx_req_i(sir_tx_req_i), .sir_rx_i(sir_rx_i), .sir_tx_o(sir_tx_o),
    .sir_rx_pulse_o(sir_rx_pulse_o));
  udl_ir_xcvr xcvr (.clk_i(clk_i), .send_i(send), .width_i(width), .sir_tx_i(sir_tx_o),
    .sir_rx_o(sir_rx_i), .tx_width_o(tx_width));

  ////////////////////////////////////////////////////////////////////
  always #2 clk_i = ~clk_i;
  // Accepted receive pulses
  always @(posedge clk_i) if (sir_rx_pulse_o === 1'b1) acc++;
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Bus cycles leave one idle cycle so a strobe is never set twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask : rd
  // Cycles spanned by n tick intervals, counted from the first tick
  task automatic span(input logic lp, input int n, output int cycles);
    int k;
    int t;
    k = 0;
    cycles = 0;
    for (t = 0; t < 3000 && k <= n; t++) begin
      @(posedge clk_i);
      #1;
      if ((lp ? low_power_x16_tick_o : baud_x16_tick_o) === 1'b1) k++;
      if (k > 0) cycles++;
    end
    // Hand back on a rising edge so the next stimulus is edge-aligned
    @(posedge clk_i);
  endtask : span
  task automatic give_verdict();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic p, e, s, f;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(fifo_depth_o, 32'h1);
    foreach (offs[i]) begin
      rd(offs[i], 32'h0);
      wr(offs[i], 32'hffffffff);
      rd(offs[i], masks[i]);
    end
    foreach (offs[i]) wr(offs[i], 32'h0);
    wr(12'h040, 32'hffffffff);
    rd(12'h040, 32'h0);
    $display("Test registers done");
    span(1'b0, 8, n);
    check(n, 32'h9);
    wr(12'h024, 32'h4);
    span(1'b0, 8, n);
    check(n, 32'h9);
    char_busy_i <= 1'b1;
    wr(12'h02c, 32'h60);
    rd(12'h034, 32'h3);
    span(1'b0, 8, n);
    check(n, 32'h9);
    char_busy_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    span(1'b0, 8, n);
    check(n, 32'h21);
    wr(12'h028, 32'h20);
    wr(12'h02c, 32'h60);
    repeat (3) @(posedge clk_i);
    span(1'b0, 8, n);
    check(n, 32'h25);
    $display("Test baud done");
    span(1'b1, 8, n);
    check(n, 32'h0);
    wr(12'h020, {24'h0, LPD});
    span(1'b1, 8, n);
    check(n, 32'h8 * LPD + 32'h1);
    wr(12'h030, 32'h1);
    sir_tx_req_i <= 1'b1;
    @(posedge clk_i);
    sir_tx_req_i <= 1'b0;
    repeat (450) @(posedge clk_i);
    check(tx_width >= 10'h111 && tx_width <= 10'h198, 32'h1);
    for (int i = 0; i < 2; i++) begin
      send <= 1'b1;
      width <= {1'b0, LPD} - 9'h001 + 9'(i);
      @(posedge clk_i);
      send <= 1'b0;
      repeat (160) @(posedge clk_i);
      check(acc, i);
    end
    // Normal mode passes even a two-clock pulse
    wr(12'h030, 32'h0);
    send <= 1'b1;
    width <= 9'h002;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(acc, 32'h2);
    $display("Test infrared done");
    foreach (lcs[i]) begin
      wr(12'h02c, {24'h0, lcs[i]});
      tx_data_i <= 8'h07;
      rx_data_i <= 8'h07;
      rx_parity_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      p = lcs[i][1];
      e = lcs[i][2];
      s = lcs[i][3];
      f = lcs[i][4];
      check({tx_parity_bit_o, rx_parity_err_o, tx_stop_bits_o, tx_frame_bits_o, fifo_depth_o,
        break_o}, {p & e, p & !e, s ? 2'h2 : 2'h1, 4'ha + {3'h0, p} + {3'h0, s},
        f ? 8'h10 : 8'h01, lcs[i][0]});
      @(posedge clk_i);
    end
    $display("Test line control done");
    give_verdict();
  end
endmodule : tb

bind udl_top udl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_data_i(tx_data_i),
  .baud_x16_tick_o(baud_x16_tick_o), .low_power_x16_tick_o(low_power_x16_tick_o),
  .tx_parity_bit_o(tx_parity_bit_o), .tx_frame_bits_o(tx_frame_bits_o),
  .rx_frame_bits_o(rx_frame_bits_o), .tx_stop_bits_o(tx_stop_bits_o),
  .fifo_depth_o(fifo_depth_o), .sir_tx_req_i(sir_tx_req_i), .sir_tx_o(sir_tx_o));
